// ===== pkg/rcf_pkg.sv
// radio config fields: register map, field layout, reset values, codes
// assumes one 250 MHz clock and a classic wishbone byte address
`default_nettype none
package rcf_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int unsigned ADR_W     = 4;
  localparam logic [3:0]  OFS_CTRL  = 4'h0;  // repeat, bypass, speed
  localparam logic [3:0]  OFS_WIDTH = 4'h4;  // address and payload widths
  localparam logic [3:0]  OFS_IDENT = 4'h8;  // own receive identity
  localparam logic [3:0]  OFS_STAT  = 4'hC;  // read-only state
  // ---------------------------------------------------------------
  // field positions and widths
  // ---------------------------------------------------------------
  localparam int CTRL_REPEAT = 0;
  localparam int CTRL_BYPASS = 1;
  localparam int CTRL_SPD_LO = 2;
  localparam int WID_RXA_LO  = 0;
  localparam int WID_TXA_LO  = 4;
  localparam int WID_RXP_LO  = 8;
  localparam int WID_TXP_LO  = 16;
  localparam int STAT_SEND   = 0;
  localparam int STAT_MATCH  = 1;
  localparam int STAT_CNT_LO = 8;
  localparam int ALEN_W      = 3;
  localparam int PLEN_W      = 6;
  localparam int SPD_W       = 2;
  localparam int CNT_W       = 8;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic              RST_REPEAT = 1'h0;
  localparam logic              RST_BYPASS = 1'h0;
  localparam logic [ALEN_W-1:0] RST_RXA    = 3'h4;
  localparam logic [ALEN_W-1:0] RST_TXA    = 3'h4;
  localparam logic [PLEN_W-1:0] RST_RXP    = 6'h20;
  localparam logic [PLEN_W-1:0] RST_TXP    = 6'h20;
  localparam logic [31:0]       RST_IDENT  = 32'hE7E7E7E7;
  localparam logic [SPD_W-1:0]  RST_SPD    = 2'h0;
  // ---------------------------------------------------------------
  // codes
  // ---------------------------------------------------------------
  localparam logic [ALEN_W-1:0] ALEN_1B = 3'h1;
  localparam logic [ALEN_W-1:0] ALEN_4B = 3'h4;
  localparam logic [SPD_W-1:0]  SPD_4M  = 2'h0;
  localparam logic [SPD_W-1:0]  SPD_2M  = 2'h1;
  localparam logic [SPD_W-1:0]  SPD_1M  = 2'h2;
  localparam logic [SPD_W-1:0]  SPD_05M = 2'h3;
  // ---------------------------------------------------------------
  // timing: cpu tick by phase accumulator, exact for all four rates
  // ---------------------------------------------------------------
  localparam int CLK_KHZ  = 250000;
  localparam int F4M_KHZ  = 4000;
  localparam int F2M_KHZ  = 2000;
  localparam int F1M_KHZ  = 1000;
  localparam int F05M_KHZ = 500;
  localparam int ACC_MOD  = 500;
  localparam int ACC_W    = 10;
  localparam int INC_4M   = F4M_KHZ * ACC_MOD / CLK_KHZ;
  localparam int INC_2M   = F2M_KHZ * ACC_MOD / CLK_KHZ;
  localparam int INC_1M   = F1M_KHZ * ACC_MOD / CLK_KHZ;
  localparam int INC_05M  = F05M_KHZ * ACC_MOD / CLK_KHZ;
  // send sequencer states
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_SEND, SEQ_HOLD} rcf_seq_t;
  // accumulator step for a speed code
  function automatic logic [ACC_W-1:0] rcf_spd_inc(input logic [SPD_W-1:0] spd);
    unique case (spd)
      SPD_4M:  return ACC_W'(INC_4M);
      SPD_2M:  return ACC_W'(INC_2M);
      SPD_1M:  return ACC_W'(INC_1M);
      SPD_05M: return ACC_W'(INC_05M);
    endcase
  endfunction
  // byte mask of identity bytes taking part; zero for unsupported codes
  function automatic logic [31:0] rcf_byte_mask(input logic [ALEN_W-1:0] alen);
    logic [31:0] m;
    m = '0;
    if (alen >= ALEN_1B && alen <= ALEN_4B) begin
      for (int i = 0; i < 4; i++) begin
        if (ALEN_W'(i) < alen) m[8*i +: 8] = 8'hFF;
      end
    end
    return m;
  endfunction
  // wishbone byte-lane merge of write data into an old word
  function automatic logic [31:0] rcf_merge(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0]  sel);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[8*i +: 8] = new_w[8*i +: 8];
    end
    return r;
  endfunction
endpackage
`default_nettype wire

// ===== design/rcf_sync2.sv
// two-flop synchroniser for one asynchronous level
// assumes the input may change at any time relative to clk_i
`timescale 1ns/10ps
`default_nettype none
module rcf_sync2 (
  input  wire logic clk_i,  // system clock
  input  wire logic rst_i,  // synchronous reset, high
  input  wire logic d_i,    // asynchronous level
  output logic      q_o     // level on clk_i
);
  logic meta_q;  // first flop, read only by the second
  // ---------------------------------------------------------------
  // two flops in a row
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      q_o    <= 1'b0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ===== design/rcf_cpu_tick.sv
// cpu clock enable: one-cycle pulse at the selected cpu rate
// assumes clk_i at 250 MHz; xo_tick_i from logic on clk_i
`timescale 1ns/10ps
`default_nettype none
module rcf_cpu_tick
  import rcf_pkg::*;
(
  input  wire logic             clk_i,      // system clock
  input  wire logic             rst_i,      // synchronous reset, high
  input  wire logic [SPD_W-1:0] spd_i,      // speed code
  input  wire logic             bypass_i,   // crystal drives cpu
  input  wire logic             xo_tick_i,  // crystal rate tick
  output logic                  tick_o      // cpu clock enable
);
  logic [ACC_W-1:0] acc_q;  // phase accumulator
  logic [ACC_W:0]   sum;    // next phase, one bit wider
  assign sum = {1'b0, acc_q} + {1'b0, rcf_spd_inc(spd_i)};
  // ---------------------------------------------------------------
  // accumulator wraps at the modulus, pulse on wrap
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_q  <= '0;
      tick_o <= 1'b0;
    end else if (bypass_i) begin  // crystal tick passes through
      acc_q  <= '0;
      tick_o <= xo_tick_i;
    end else if (sum >= (ACC_W+1)'(ACC_MOD)) begin  // wrap
      acc_q  <= ACC_W'(sum - (ACC_W+1)'(ACC_MOD));
      tick_o <= 1'b1;
    end else begin
      acc_q  <= sum[ACC_W-1:0];
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== design/rcf_bank.sv
// radio config field bank: wishbone slave, repeat-send sequencer,
// receive identity compare and cpu clock enable selection
// assumes a classic wishbone master on clk_i, radio enable pins
// asynchronous, packet_done_i and rx address from logic on clk_i
//
// Local design decisions: the Wishbone register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module rcf_bank
  import rcf_pkg::*;
(
  input  wire logic              clk_i,                  // 250 MHz
  input  wire logic              rst_i,                  // sync, high
  input  wire logic              wb_cyc_i,               // bus cycle
  input  wire logic              wb_stb_i,               // strobe
  input  wire logic              wb_we_i,                // write
  input  wire logic [ADR_W-1:0]  wb_adr_i,               // byte address
  input  wire logic [3:0]        wb_sel_i,               // byte lanes
  input  wire logic [31:0]       wb_dat_i,               // write data
  output logic      [31:0]       wb_dat_o,               // read data
  output logic                   wb_ack_o,               // answer
  input  wire logic              radio_chip_enable_i,    // pin
  input  wire logic              transmit_select_i,      // pin
  input  wire logic              packet_done_i,          // packet sent
  output logic                   send_start_o,           // start pulse
  output logic                   sending_o,              // send active
  input  wire logic [31:0]       rx_addr_i,              // received addr
  input  wire logic              rx_addr_valid_i,        // addr strobe
  output logic                   addr_match_o,           // identity hit
  output logic      [ALEN_W-1:0] receive_addr_len_o,     // rx addr bytes
  output logic      [ALEN_W-1:0] send_addr_len_o,        // tx addr bytes
  output logic      [PLEN_W-1:0] receive_payload_len_o,  // rx bytes
  output logic      [PLEN_W-1:0] send_payload_len_o,     // tx bytes
  input  wire logic              xo_tick_i,              // crystal tick
  output logic                   cpu_clk_en_o            // cpu enable
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic              repeat_q;  // resend flag
  logic              bypass_q;  // crystal drives cpu
  logic [SPD_W-1:0]  spd_q;     // cpu speed code
  logic [ALEN_W-1:0] rxa_q;     // rx address width
  logic [ALEN_W-1:0] txa_q;     // tx address width
  logic [PLEN_W-1:0] rxp_q;     // rx payload width
  logic [PLEN_W-1:0] txp_q;     // tx payload width
  logic [31:0]       ident_q;   // own receive identity
  logic              match_q;   // last compare result
  logic [CNT_W-1:0]  cnt_q;     // packets sent, wraps
  logic              ack_q;     // bus answer
  logic [31:0]       rdat_q;    // read data
  rcf_seq_t          seq_q;     // sequencer state
  logic              start_q;   // start pulse
  logic              ce_s;      // synced chip enable
  logic              tx_s;      // synced transmit select
  logic              both;      // radio asked to send
  logic              req;       // request pending
  logic              wr_fire;   // write takes effect
  logic [31:0]       ctrl_img;  // control word view
  logic [31:0]       wid_img;   // width word view
  logic [31:0]       stat_img;  // status word view
  logic [31:0]       ctrl_new;  // merged control write
  logic [31:0]       wid_new;   // merged width write
  logic [31:0]       id_new;    // merged identity write
  logic [31:0]       rd_mux;    // read selection
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  rcf_sync2 u_sync_ce (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (radio_chip_enable_i),
    .q_o   (ce_s)
  );
  rcf_sync2 u_sync_tx (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (transmit_select_i),
    .q_o   (tx_s)
  );
  assign both = ce_s & tx_s;
  // ---------------------------------------------------------------
  // register images
  // ---------------------------------------------------------------
  // control word: repeat, bypass, speed
  always_comb begin
    ctrl_img                                = '0;
    ctrl_img[CTRL_REPEAT]                   = repeat_q;
    ctrl_img[CTRL_BYPASS]                   = bypass_q;
    ctrl_img[CTRL_SPD_LO +: SPD_W]          = spd_q;
  end
  // width word: two address widths, two payload widths
  always_comb begin
    wid_img                                 = '0;
    wid_img[WID_RXA_LO +: ALEN_W]           = rxa_q;
    wid_img[WID_TXA_LO +: ALEN_W]           = txa_q;
    wid_img[WID_RXP_LO +: PLEN_W]           = rxp_q;
    wid_img[WID_TXP_LO +: PLEN_W]           = txp_q;
  end
  // status word: send active, match, packet count
  always_comb begin
    stat_img                                = '0;
    stat_img[STAT_SEND]                     = sending_o;
    stat_img[STAT_MATCH]                    = match_q;
    stat_img[STAT_CNT_LO +: CNT_W]          = cnt_q;
  end
  assign ctrl_new = rcf_merge(ctrl_img, wb_dat_i, wb_sel_i);
  assign wid_new  = rcf_merge(wid_img, wb_dat_i, wb_sel_i);
  assign id_new   = rcf_merge(ident_q, wb_dat_i, wb_sel_i);
  // ---------------------------------------------------------------
  // wishbone slave: one wait state, ack for one cycle
  // ---------------------------------------------------------------
  assign req     = wb_cyc_i & wb_stb_i;
  assign wr_fire = req & ack_q & wb_we_i;  // write lands at ack edge
  // read mux; unmapped offsets read zero
  always_comb begin
    unique case (wb_adr_i)
      OFS_CTRL:  rd_mux = ctrl_img;
      OFS_WIDTH: rd_mux = wid_img;
      OFS_IDENT: rd_mux = ident_q;
      OFS_STAT:  rd_mux = stat_img;
      default:   rd_mux = '0;
    endcase
  end
  // ack and read data, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= '0;
    end else begin
      ack_q  <= req & ~ack_q;
      rdat_q <= (req & ~ack_q) ? rd_mux : '0;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      repeat_q <= RST_REPEAT;
      bypass_q <= RST_BYPASS;
      spd_q    <= RST_SPD;
    end else if (wr_fire && wb_adr_i == OFS_CTRL) begin
      repeat_q <= ctrl_new[CTRL_REPEAT];
      bypass_q <= ctrl_new[CTRL_BYPASS];
      spd_q    <= ctrl_new[CTRL_SPD_LO +: SPD_W];
    end
  end
  // ---------------------------------------------------------------
  // width register; unsupported codes stored as written
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxa_q <= RST_RXA;
      txa_q <= RST_TXA;
      rxp_q <= RST_RXP;
      txp_q <= RST_TXP;
    end else if (wr_fire && wb_adr_i == OFS_WIDTH) begin
      rxa_q <= wid_new[WID_RXA_LO +: ALEN_W];
      txa_q <= wid_new[WID_TXA_LO +: ALEN_W];
      rxp_q <= wid_new[WID_RXP_LO +: PLEN_W];
      txp_q <= wid_new[WID_TXP_LO +: PLEN_W];
    end
  end
  assign receive_addr_len_o    = rxa_q;
  assign send_addr_len_o       = txa_q;
  assign receive_payload_len_o = rxp_q;
  assign send_payload_len_o    = txp_q;
  // ---------------------------------------------------------------
  // identity register and compare
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ident_q <= RST_IDENT;
    end else if (wr_fire && wb_adr_i == OFS_IDENT) begin
      ident_q <= id_new;
    end
  end
  // compare only the selected low bytes; unsupported width never hits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      match_q <= 1'b0;
    end else if (rx_addr_valid_i) begin
      match_q <= (rcf_byte_mask(rxa_q) != '0) &&
                 (((rx_addr_i ^ ident_q) & rcf_byte_mask(rxa_q)) == '0);
    end
  end
  assign addr_match_o = match_q;
  // ---------------------------------------------------------------
  // send sequencer
  // ---------------------------------------------------------------
  // idle until enable and select both high, then send;
  // repeat resends while both stay high, else hold until they drop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_q   <= SEQ_IDLE;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      unique case (seq_q)
        SEQ_IDLE: begin
          if (both) begin  // first packet
            seq_q   <= SEQ_SEND;
            start_q <= 1'b1;
          end
        end
        SEQ_SEND: begin
          if (packet_done_i && repeat_q && both) begin
            start_q <= 1'b1;  // resend same buffer
          end else if (packet_done_i && both) begin
            seq_q <= SEQ_HOLD;  // single send done
          end else if (packet_done_i || !both) begin
            seq_q <= SEQ_IDLE;  // radio released
          end
        end
        SEQ_HOLD: begin
          if (!both) begin  // wait for release
            seq_q <= SEQ_IDLE;
          end
        end
        default: begin
          seq_q <= SEQ_IDLE;
        end
      endcase
    end
  end
  assign send_start_o = start_q;
  assign sending_o    = (seq_q == SEQ_SEND);
  // packets sent counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (sending_o && packet_done_i) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end
  // ---------------------------------------------------------------
  // cpu clock enable
  // ---------------------------------------------------------------
  rcf_cpu_tick u_tick (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .spd_i     (spd_q),
    .bypass_i  (bypass_q),
    .xo_tick_i (xo_tick_i),
    .tick_o    (cpu_clk_en_o)
  );
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [ACC_W-1:0] gap_q;  // cycles since last cpu tick
  logic             gap_ok_q;  // gap spans one steady speed
  // gap helper; invalid across speed or source changes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap_q    <= '0;
      gap_ok_q <= 1'b0;
    end else if (wr_fire && wb_adr_i == OFS_CTRL
                 && (spd_q != ctrl_new[CTRL_SPD_LO +: SPD_W]
                     || bypass_q != ctrl_new[CTRL_BYPASS])) begin
      gap_q    <= '0;
      gap_ok_q <= 1'b0;
    end else if (cpu_clk_en_o) begin
      gap_q    <= ACC_W'(1);
      // first tick after a change may still carry the old phase
      gap_ok_q <= ~bypass_q && (gap_q != '0);
    end else if (gap_q < ACC_W'(ACC_MOD)) begin
      gap_q    <= gap_q + ACC_W'(1);
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_repeat_resend:
    assert property (seq_q == SEQ_SEND && packet_done_i && repeat_q && both
                     |=> send_start_o && sending_o)
    else $error("repeat send did not restart");
  a_single_send:
    assert property (seq_q == SEQ_SEND && packet_done_i && !repeat_q && both
                     |=> !send_start_o ##1 (!send_start_o || !$past(both)))
    else $error("single send was repeated");
  a_rx_width_rst:
    assert property ($past(rst_i) |-> receive_addr_len_o == RST_RXA)
    else $error("rx address width reset wrong");
  a_tx_width_wr:
    assert property (wr_fire && wb_adr_i == OFS_WIDTH && wb_sel_i[0]
                     |=> send_addr_len_o == $past(wb_dat_i[WID_TXA_LO +: ALEN_W]))
    else $error("tx address width not written");
  a_payload_rst:
    assert property ($past(rst_i) |-> receive_payload_len_o == RST_RXP
                     && send_payload_len_o == RST_TXP)
    else $error("payload width reset wrong");
  a_payload_hold:
    assert property (!(wr_fire && wb_adr_i == OFS_WIDTH)
                     |=> $stable(send_payload_len_o) && $stable(receive_payload_len_o))
    else $error("payload width changed without write");
  a_ident_one_byte:
    assert property (rx_addr_valid_i && rxa_q == ALEN_1B
                     && rx_addr_i[7:0] == ident_q[7:0] |=> addr_match_o)
    else $error("one byte identity compare missed");
  a_ident_four_byte:
    assert property (rx_addr_valid_i && rxa_q == ALEN_4B
                     && rx_addr_i != ident_q |=> !addr_match_o)
    else $error("four byte identity compare false hit");
  a_cpu_rate:
    assert property (cpu_clk_en_o && gap_ok_q && !bypass_q |->
                     gap_q >= ACC_W'(ACC_MOD) / rcf_spd_inc(spd_q) &&
                     gap_q <= (ACC_W'(ACC_MOD) + rcf_spd_inc(spd_q) - ACC_W'(1))
                              / rcf_spd_inc(spd_q))
    else $error("cpu tick spacing wrong for speed code");
  a_src_reset:
    assert property ($past(rst_i) |-> !bypass_q && !cpu_clk_en_o)
    else $error("cpu source select reset wrong");
  a_src_bypass:
    assert property ($past(bypass_q) |-> cpu_clk_en_o == $past(xo_tick_i))
    else $error("crystal tick not passed to cpu");
  // reset values seen at the first edge after release
  a_repeat_reset:
    assert property ($past(rst_i) |-> !repeat_q && !send_start_o && !sending_o)
    else $error("send sequencer reset wrong");
  a_tx_width_rst:
    assert property ($past(rst_i) |-> send_addr_len_o == RST_TXA)
    else $error("tx address width reset wrong");
  a_ident_rst:
    assert property ($past(rst_i) |-> ident_q == RST_IDENT && !addr_match_o)
    else $error("identity reset wrong");
  a_speed_rst:
    assert property ($past(rst_i) |-> spd_q == RST_SPD)
    else $error("cpu speed reset wrong");
  // fields move only on their own write, match only on its strobe, no start while held
  a_hold_no_start:
    assert property (seq_q == SEQ_HOLD |=> !send_start_o)
    else $error("start while single send held");
  a_tx_width_hold:
    assert property (!(wr_fire && wb_adr_i == OFS_WIDTH) |=> $stable(send_addr_len_o))
    else $error("tx address width changed without write");
  a_ident_hold:
    assert property (!(wr_fire && wb_adr_i == OFS_IDENT) |=> $stable(ident_q))
    else $error("identity changed without write");
  a_match_hold:
    assert property (!rx_addr_valid_i |=> $stable(addr_match_o))
    else $error("match flag changed without strobe");
endmodule
`default_nettype wire

// ===== test/rcf_radio_model.sv
// radio engine stand-in: answers each send start with a done pulse
// assumes send_start_i is a one-cycle pulse on clk_i
`timescale 1ns/10ps
`default_nettype none
module rcf_radio_model (
  input  wire logic       clk_i,          // system clock
  input  wire logic       rst_i,          // sync reset, high
  input  wire logic       send_start_i,   // start pulse
  input  wire logic [7:0] dly_i,          // send time in cycles
  output logic            packet_done_o   // done pulse
);
  logic [7:0] cnt_q;  // cycles left, zero when idle
  // count down from a start, pulse done when one is left
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q         <= 8'h00;
      packet_done_o <= 1'b0;
    end else begin
      packet_done_o <= (cnt_q == 8'h01);
      if (send_start_i) cnt_q <= dly_i;
      else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule
`default_nettype wire

// ===== test/rcf_bank_tb.sv
// bench for the config field bank: reads are checked from a queue
// assumes rcf_pkg and the radio engine stand-in compiled first
`timescale 1ns/10ps
`default_nettype none
module rcf_bank_tb;
  import rcf_pkg::*;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic        ce = 0, tx = 0, vld = 0, xo = 0, ack, done, start, match, cpu_en, sending;
  logic [2:0]  ral, sal;              // address width outputs
  logic [5:0]  rpl, spl;              // payload width outputs
  logic [3:0]  adr = 4'h0, sel = 4'hF;
  logic [31:0] dat = 32'h0, rdat, rxa = 32'h0, r;
  logic [7:0]  dly = 8'h14;
  logic [1:0]  sfr_mirror;           // bench's copy of the speed code being written
  int          miscompares = 0, compares = 0, cycles = 0, n_start, n_cpu, n_xo, e;
  logic [31:0] exp_q[$];             // expected read words, oldest first
  always #2 clk_i = ~clk_i;
  rcf_bank u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .radio_chip_enable_i(ce), .transmit_select_i(tx),
    .packet_done_i(done), .send_start_o(start), .sending_o(sending), .rx_addr_i(rxa),
    .rx_addr_valid_i(vld), .addr_match_o(match), .receive_addr_len_o(ral),
    .send_addr_len_o(sal), .receive_payload_len_o(rpl), .send_payload_len_o(spl),
    .xo_tick_i(xo), .cpu_clk_en_o(cpu_en));
  rcf_radio_model u_radio (.clk_i(clk_i), .rst_i(rst_i), .send_start_i(start),
    .dly_i(dly), .packet_done_o(done));
  // one comparison, counted
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // counts, verdict, stop
  task automatic end_of_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // read with its expected word noted first
  task automatic rd(input logic [3:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    wb(1'b0, a, 32'h0);
  endtask
  // present one received address, check the match flag
  task automatic probe(input logic [31:0] a, input logic x);
    @(posedge clk_i);
    rxa <= a;
    vld <= 1'b1;
    @(posedge clk_i);
    vld <= 1'b0;
    @(negedge clk_i);
    chk32({31'h0, match}, {31'h0, x});
  endtask
  // watcher: timeout, pulse counts, read answers against the queue
  always @(posedge clk_i) begin
    cycles++;
    xo <= ($urandom_range(0, 9) == 0);
    if (start === 1'b1) n_start++;
    if (cpu_en === 1'b1) n_cpu++;
    if (xo === 1'b1) n_xo++;
    if (ack === 1'b1 && we === 1'b0) chk32(rdat, exp_q.pop_front());
    if (cycles == 40000) begin
      miscompares++;
      end_of_test();
    end
  end
  // main sequence
  initial begin
    void'($urandom(32'hA77E3863));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(4'h0, 32'h0000_0000);
    rd(4'h4, 32'h0020_2044);
    rd(4'h8, 32'hE7E7_E7E7);
    wb(1'b1, 4'h2, $urandom);
    rd(4'h2, 32'h0000_0000);
    $display("reset values and unmapped place done");
    r = $urandom;
    wb(1'b1, 4'h8, r);
    rd(4'h8, r);
    wb(1'b1, 4'h4, 32'h0001_0111);
    rd(4'h4, 32'h0001_0111);
    chk32(32'({ral, sal, rpl, spl}), 32'({3'h1,3'h1,6'h01,6'h01}));
    probe({~r[31:8], r[7:0]}, 1'b1);
    wb(1'b1, 4'h4, 32'h0020_2044);
    probe({~r[31:8], r[7:0]}, 1'b0);
    probe(r, 1'b1);
    $display("widths and identity compare done");
    dly <= 8'($urandom_range(3, 40));
    wb(1'b1, 4'h0, 32'h1);
    n_start = 0;
    ce <= 1'b1;
    tx <= 1'b1;
    repeat (300) @(posedge clk_i);
    chk32(32'(n_start > 2), 32'h1);
    chk32({31'h0, sending}, 32'h1);
    ce <= 1'b0;
    tx <= 1'b0;
    repeat (60) @(posedge clk_i);
    rst_i <= 1'b1;  // mid-run reset clears the repeat flag
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(4'h0, 32'h0000_0000);
    chk32(32'({ral, sal, rpl, spl}), 32'({RST_RXA, RST_TXA, RST_RXP, RST_TXP}));
    n_start = 0;
    ce <= 1'b1;
    tx <= 1'b1;
    repeat (300) @(posedge clk_i);
    chk32(32'(n_start), 32'h1);
    chk32({31'h0, sending}, 32'h0);
    rd(4'hC, 32'h0000_0100);
    ce <= 1'b0;
    tx <= 1'b0;
    $display("repeat send done");
    for (int s = 0; s < 4; s++) begin
      sfr_mirror = 2'(s);
      wb(1'b1, 4'h0, {28'h0, sfr_mirror, 2'h0});
      repeat (20) @(posedge clk_i);
      n_cpu = 0;
      e = 16 >> s;
      repeat (1000) @(posedge clk_i);
      chk32(32'(n_cpu >= e - 1 && n_cpu <= e + 1), 32'h1);
    end
    $display("cpu speed codes done");
    wb(1'b1, 4'h0, 32'h0000_0002);
    repeat (20) @(posedge clk_i);
    n_cpu = 0;
    n_xo = 0;
    repeat (1000) @(posedge clk_i);
    chk32(32'(n_cpu >= n_xo - 1 && n_cpu <= n_xo + 1), 32'h1);
    $display("cpu source select done");
    end_of_test();
  end
endmodule
`default_nettype wire
